// *** verilog/pcd_prefix_code_decoder.sv ***
`timescale 1ns/1ps
module pcd_prefix_code_decoder (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcd_pkg::pcd_apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire pcd_pkg::pcd_insn_t i_insn,
  input wire logic [7:0] i_program_bank,
  input wire logic i_irq_req,
  output pcd_pkg::pcd_exec_t o_exec,
  output logic o_irq_take,
  output logic o_stack_select
);

  logic [4:0] bank_pointer_ff;
  logic stack_select_ff;
  logic [7:0] bank_ff [4];
  logic pend_bank_ff;
  pcd_pkg::pcd_bsel_t pend_bsel_ff;
  logic pend_common_ff;
  logic pend_hold_ff;
  logic irq_held_ff;
  logic irq_take_ff;
  logic [31:0] prdata_ff;
  pcd_pkg::pcd_exec_t exec_ff;
  pcd_pkg::pcd_exec_t nxt_exec;

  logic setup;
  logic access;
  logic hit;
  logic wr;
  logic is_bank_pfx;
  logic is_prefix;
  logic is_carry;
  logic irq_block;
  logic consume;
  logic apply;
  logic flag_exempt;
  logic irq_take;
  logic [31:0] rd_mux;
  pcd_pkg::pcd_space_t space;
  logic [7:0] bank_sel;
  pcd_pkg::pcd_bsel_t pfx_bsel;
  logic common_now;
  logic hold_now;

  // APB decode; zero-wait slave, errors on unmapped words
  assign setup = i_apb.psel & ~i_apb.penable;
  assign access = i_apb.psel & i_apb.penable;
  assign hit = (i_apb.paddr == pcd_pkg::PCD_CTRL_OFS) | (i_apb.paddr == pcd_pkg::PCD_BANK_OFS) |
               (i_apb.paddr == pcd_pkg::PCD_STAT_OFS);
  assign wr = access & i_apb.pwrite & hit;
  assign o_pready = access;
  assign o_pslverr = access & ~hit;
  assign o_prdata = prdata_ff;

  // Instruction classes
  assign is_bank_pfx = i_insn.cls inside {pcd_pkg::CLS_PFX_PROGRAM, pcd_pkg::CLS_PFX_DATA,
                                          pcd_pkg::CLS_PFX_ADDITIONAL, pcd_pkg::CLS_PFX_STACK};
  assign is_prefix = is_bank_pfx | (i_insn.cls == pcd_pkg::CLS_PFX_COMMON) |
                     (i_insn.cls == pcd_pkg::CLS_PFX_FLAG_HOLD);
  assign is_carry = i_insn.cls inside {pcd_pkg::CLS_CCR_LOGIC, pcd_pkg::CLS_POP_PS,
                                       pcd_pkg::CLS_MOV_ILM};
  // Carry-over classes leave every pending prefix in place
  // Both groups together form the interrupt-disable set
  assign irq_block = is_prefix | is_carry;
  // Only an instruction outside the set consumes the pending prefixes
  assign consume = i_insn.valid & ~irq_block;
  // A resumed string step has lost its prefix context
  assign apply = consume & ~i_insn.resume;
  assign flag_exempt = i_insn.cls inside {pcd_pkg::CLS_SWI, pcd_pkg::CLS_INTERRUPT_RETURN,
                                          pcd_pkg::CLS_CTX_JUMP};
  // Request is level-held by the controller, so waiting here loses nothing
  assign irq_take = consume & i_irq_req;

  // Pending modifiers reach only an instruction that consumes them
  assign common_now = apply & pend_common_ff;
  assign hold_now = apply & pend_hold_ff & ~flag_exempt;

  // Bank prefix class to bank choice; spelled out so class codes may be renumbered freely
  always_comb begin
    pfx_bsel = pcd_pkg::BSEL_DATA;
    case (i_insn.cls)
      pcd_pkg::CLS_PFX_PROGRAM: pfx_bsel = pcd_pkg::BSEL_PROGRAM;
      pcd_pkg::CLS_PFX_DATA: pfx_bsel = pcd_pkg::BSEL_DATA;
      pcd_pkg::CLS_PFX_ADDITIONAL: pfx_bsel = pcd_pkg::BSEL_ADDITIONAL;
      pcd_pkg::CLS_PFX_STACK: pfx_bsel = pcd_pkg::BSEL_STACK;
      default: pfx_bsel = pcd_pkg::BSEL_DATA;
    endcase
  end

  // Control register: software writes steer the stack bank and register bank
  // Only the low five pointer bits are kept; the rest of the lane reads back as zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_pointer_ff <= pcd_pkg::PCD_BP_RST;
    end else if (wr && i_apb.paddr == pcd_pkg::PCD_CTRL_OFS && i_apb.pstrb[0]) begin
      bank_pointer_ff <= i_apb.pwdata[pcd_pkg::PCD_CTRL_BP_LSB +: pcd_pkg::PCD_BP_W];
    end
  end

  // Stack select; interrupt acceptance wins over a software clear
  // A clear written in the acceptance cycle is lost, so software must write it again
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stack_select_ff <= pcd_pkg::PCD_STACK_SEL_RST;
    end else if (irq_take) begin
      stack_select_ff <= 1'b1;
    end else if (wr && i_apb.paddr == pcd_pkg::PCD_CTRL_OFS && i_apb.pstrb[1]) begin
      stack_select_ff <= i_apb.pwdata[pcd_pkg::PCD_CTRL_SEL_BIT];
    end
  end

  // Bank registers: data, additional, user stack, system stack, one byte lane each
  // Program bank is not writable here; it arrives from the fetch side
  for (genvar g = 0; g < 4; g++) begin : g_bank
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        bank_ff[g] <= pcd_pkg::PCD_BANK_RST;
      end else if (wr && i_apb.paddr == pcd_pkg::PCD_BANK_OFS && i_apb.pstrb[g]) begin
        bank_ff[g] <= i_apb.pwdata[8*g +: 8];
      end
    end
  end

  // Pending bank prefix; a later competitor overwrites the earlier one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_bank_ff <= 1'b0;
      pend_bsel_ff <= pcd_pkg::BSEL_DATA;
    end else if (i_insn.valid && is_bank_pfx) begin
      pend_bank_ff <= 1'b1;
      pend_bsel_ff <= pfx_bsel;
    end else if (consume) begin
      pend_bank_ff <= 1'b0;
    end
  end

  // Common-bank and flag-hold prefixes accumulate alongside a bank prefix
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_common_ff <= 1'b0;
      pend_hold_ff <= 1'b0;
    end else if (i_insn.valid) begin
      if (i_insn.cls == pcd_pkg::CLS_PFX_COMMON) begin
        pend_common_ff <= 1'b1;
      end else if (consume) begin
        pend_common_ff <= 1'b0;
      end
      if (i_insn.cls == pcd_pkg::CLS_PFX_FLAG_HOLD) begin
        pend_hold_ff <= 1'b1;
      end else if (consume) begin
        pend_hold_ff <= 1'b0;
      end
    end
  end

  // Space selection per class
  // The class list is exhaustive, so every class has exactly one decided space
  always_comb begin
    space = i_insn.dflt_space;
    unique case (i_insn.cls)
      pcd_pkg::CLS_STRING: begin
        space = i_insn.dflt_space;
      end
      pcd_pkg::CLS_STACK_WORD, pcd_pkg::CLS_POP_PS: begin
        space = stack_select_ff ? pcd_pkg::SPC_SYSTEM_STACK : pcd_pkg::SPC_USER_STACK;
      end
      pcd_pkg::CLS_IO: begin
        space = pcd_pkg::SPC_IO;
      end
      pcd_pkg::CLS_INTERRUPT_RETURN: begin
        space = pcd_pkg::SPC_SYSTEM_STACK;
      end
      pcd_pkg::CLS_PLAIN, pcd_pkg::CLS_CCR_LOGIC, pcd_pkg::CLS_MOV_ILM, pcd_pkg::CLS_SWI,
      pcd_pkg::CLS_CTX_JUMP, pcd_pkg::CLS_PFX_PROGRAM, pcd_pkg::CLS_PFX_DATA,
      pcd_pkg::CLS_PFX_ADDITIONAL, pcd_pkg::CLS_PFX_STACK, pcd_pkg::CLS_PFX_COMMON,
      pcd_pkg::CLS_PFX_FLAG_HOLD: begin
        if (apply && pend_bank_ff) begin
          unique case (pend_bsel_ff)
            pcd_pkg::BSEL_PROGRAM: space = pcd_pkg::SPC_PROGRAM;
            pcd_pkg::BSEL_DATA: space = pcd_pkg::SPC_DATA;
            pcd_pkg::BSEL_ADDITIONAL: space = pcd_pkg::SPC_ADDITIONAL;
            pcd_pkg::BSEL_STACK: space = stack_select_ff ? pcd_pkg::SPC_SYSTEM_STACK : pcd_pkg::SPC_USER_STACK;
          endcase
        end
      end
    endcase
  end

  // Bank byte for the chosen space; I/O sits in the fixed bank
  // Codes six and seven leave the space logic only when passed through from dflt_space; they fall to the I/O bank
  always_comb begin
    case (space)
      pcd_pkg::SPC_PROGRAM: bank_sel = i_program_bank;
      pcd_pkg::SPC_DATA: bank_sel = bank_ff[0];
      pcd_pkg::SPC_ADDITIONAL: bank_sel = bank_ff[1];
      pcd_pkg::SPC_USER_STACK: bank_sel = bank_ff[2];
      pcd_pkg::SPC_SYSTEM_STACK: bank_sel = bank_ff[3];
      default: bank_sel = pcd_pkg::PCD_IO_BANK;
    endcase
  end

  // Resolved controls for the executing instruction
  always_comb begin
    nxt_exec.valid = i_insn.valid;
    nxt_exec.cls = i_insn.cls;
    nxt_exec.space = space;
    nxt_exec.bank = bank_sel;
    nxt_exec.regbank_en = i_insn.regbank;
    if (common_now) begin
      nxt_exec.regbank_base = pcd_pkg::PCD_REGBANK_BASE;
    end else begin
      nxt_exec.regbank_base = pcd_pkg::PCD_REGBANK_BASE +
                              {7'h00, bank_pointer_ff, 4'h0};
    end
    // Carry-over classes run as if unprefixed, so their flags still change
    nxt_exec.flag_en = i_insn.flag_write & ~hold_now;
  end

  // Execution outputs registered one cycle after the instruction
  // The register keeps the decode path away from the address adder downstream
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exec_ff <= '0;
    end else begin
      exec_ff <= nxt_exec;
    end
  end

  // Interrupt acceptance and the held-off indication
  // Level masking and the enable flag sit upstream; this block only defers sampling
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_take_ff <= 1'b0;
      irq_held_ff <= 1'b0;
    end else begin
      irq_take_ff <= irq_take;
      if (i_insn.valid && irq_block && i_irq_req) begin
        irq_held_ff <= 1'b1;
      end else if (irq_take || !i_irq_req) begin
        irq_held_ff <= 1'b0;
      end
    end
  end

  // Status bits are read-only; writes to that word are accepted and dropped
  // Read data captured in the setup phase so it is stable through access
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_apb.paddr == pcd_pkg::PCD_CTRL_OFS) begin
      rd_mux[pcd_pkg::PCD_CTRL_BP_LSB +: pcd_pkg::PCD_BP_W] = bank_pointer_ff;
      rd_mux[pcd_pkg::PCD_CTRL_SEL_BIT] = stack_select_ff;
    end else if (i_apb.paddr == pcd_pkg::PCD_BANK_OFS) begin
      rd_mux = {bank_ff[3], bank_ff[2], bank_ff[1], bank_ff[0]};
    end else if (i_apb.paddr == pcd_pkg::PCD_STAT_OFS) begin
      rd_mux[pcd_pkg::PCD_STAT_BANK_VLD_BIT] = pend_bank_ff;
      rd_mux[pcd_pkg::PCD_STAT_BANK_SEL_LSB +: 2] = pend_bsel_ff;
      rd_mux[pcd_pkg::PCD_STAT_COMMON_BIT] = pend_common_ff;
      rd_mux[pcd_pkg::PCD_STAT_HOLD_BIT] = pend_hold_ff;
      rd_mux[pcd_pkg::PCD_STAT_IRQ_HELD_BIT] = irq_held_ff;
    end
  end

  // Read capture register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign o_exec = exec_ff;
  assign o_irq_take = irq_take_ff;
  assign o_stack_select = stack_select_ff;

endmodule

// *** verilog/pcd_pkg.sv ***
package pcd_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] PCD_CTRL_OFS = 12'h000;
  localparam logic [11:0] PCD_BANK_OFS = 12'h004;
  localparam logic [11:0] PCD_STAT_OFS = 12'h008;

  // Control register fields
  localparam int PCD_CTRL_BP_LSB = 0;
  localparam int PCD_BP_W = 5;
  localparam int PCD_CTRL_SEL_BIT = 8;

  // Status register fields
  localparam int PCD_STAT_BANK_VLD_BIT = 0;
  localparam int PCD_STAT_BANK_SEL_LSB = 1;
  localparam int PCD_STAT_COMMON_BIT = 3;
  localparam int PCD_STAT_HOLD_BIT = 4;
  localparam int PCD_STAT_IRQ_HELD_BIT = 5;

  // Values after reset
  localparam logic [4:0] PCD_BP_RST = 5'h00;
  localparam logic PCD_STACK_SEL_RST = 1'b1;
  localparam logic [7:0] PCD_BANK_RST = 8'h00;

  // Register bank placement: base plus bank pointer times sixteen
  localparam logic [15:0] PCD_REGBANK_BASE = 16'h0180;
  localparam int PCD_REGBANK_SHIFT = 4;
  localparam logic [7:0] PCD_IO_BANK = 8'h00;

  typedef enum logic [3:0] {
    CLS_PLAIN, CLS_STRING, CLS_STACK_WORD, CLS_IO,
    CLS_CCR_LOGIC, CLS_POP_PS, CLS_MOV_ILM, CLS_INTERRUPT_RETURN,
    CLS_SWI, CLS_CTX_JUMP, CLS_PFX_PROGRAM, CLS_PFX_DATA,
    CLS_PFX_ADDITIONAL, CLS_PFX_STACK, CLS_PFX_COMMON, CLS_PFX_FLAG_HOLD
  } pcd_cls_t;

  typedef enum logic [2:0] {
    SPC_PROGRAM, SPC_DATA, SPC_ADDITIONAL, SPC_USER_STACK, SPC_SYSTEM_STACK, SPC_IO
  } pcd_space_t;

  typedef enum logic [1:0] {
    BSEL_PROGRAM, BSEL_DATA, BSEL_ADDITIONAL, BSEL_STACK
  } pcd_bsel_t;

  // One executed instruction, already classified by the opcode decoder
  typedef struct packed {
    logic valid;
    pcd_cls_t cls;
    pcd_space_t dflt_space;
    logic regbank;
    logic flag_write;
    logic resume;
  } pcd_insn_t;

  // Resolved operation controls for that instruction
  typedef struct packed {
    logic valid;
    pcd_cls_t cls;
    pcd_space_t space;
    logic [7:0] bank;
    logic regbank_en;
    logic [15:0] regbank_base;
    logic flag_en;
  } pcd_exec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pcd_apb_req_t;

endpackage

// *** test/pcd_prefix_code_decoder_chk.sv ***
`timescale 1ns/1ps
module pcd_prefix_code_decoder_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcd_pkg::pcd_apb_req_t i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire pcd_pkg::pcd_insn_t i_insn,
  input wire logic [7:0] i_program_bank,
  input wire logic i_irq_req,
  input wire pcd_pkg::pcd_exec_t o_exec,
  input wire logic o_irq_take,
  input wire logic o_stack_select
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Disable set and flag-exempt classes, decoded once
  wire logic go = i_insn.valid;
  wire logic dis = i_insn.cls >= pcd_pkg::CLS_PFX_PROGRAM || i_insn.cls inside {pcd_pkg::CLS_CCR_LOGIC,
    pcd_pkg::CLS_POP_PS, pcd_pkg::CLS_MOV_ILM};
  wire logic fx = i_insn.cls inside {pcd_pkg::CLS_SWI, pcd_pkg::CLS_INTERRUPT_RETURN, pcd_pkg::CLS_CTX_JUMP};
  exec_lat_a: assert property (go && i_insn.cls < pcd_pkg::CLS_PFX_PROGRAM |=> o_exec.valid)
    else $error("no result");
  io_space_a: assert property (go && i_insn.cls == pcd_pkg::CLS_IO |=> o_exec.space == pcd_pkg::SPC_IO)
    else $error("io space");
  interrupt_return_stack_a: assert property (go && i_insn.cls == pcd_pkg::CLS_INTERRUPT_RETURN |=> o_exec.space == pcd_pkg::SPC_SYSTEM_STACK)
    else $error("return stack");
  push_stack_a: assert property (go && i_insn.cls == pcd_pkg::CLS_STACK_WORD |=> o_exec.space ==
    ($past(o_stack_select) ? pcd_pkg::SPC_SYSTEM_STACK : pcd_pkg::SPC_USER_STACK)) else $error("push stack");
  flag_exempt_a: assert property (go && fx |=> o_exec.flag_en == $past(i_insn.flag_write))
    else $error("flag exempt");
  irq_block_a: assert property (go && dis |=> !o_irq_take)
    else $error("irq after disable");
  irq_take_a: assert property (go && !dis && i_irq_req |=> o_irq_take)
    else $error("irq not taken");
  take_stack_a: assert property (o_irq_take |-> ##[0:1] o_stack_select)
    else $error("stack select");
  bank_base_a: assert property (o_exec.valid && o_exec.regbank_en |-> o_exec.regbank_base[3:0] == 4'h0 &&
    o_exec.regbank_base inside {[16'h0180:16'h0370]}) else $error("bank base");
  cover property (o_irq_take);
  cover property (o_exec.regbank_en && o_exec.regbank_base == 16'h0180);
  cover property (go && dis && i_irq_req);
endmodule
bind pcd_prefix_code_decoder pcd_prefix_code_decoder_chk chk (.i_clk(i_clk), .i_rst(i_rst), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_insn(i_insn),
  .i_program_bank(i_program_bank), .i_irq_req(i_irq_req), .o_exec(o_exec), .o_irq_take(o_irq_take),
  .o_stack_select(o_stack_select));

// *** test/pcd_prog_mem.sv ***
`timescale 1ns/1ps
module pcd_prog_mem (
  input wire logic i_clk,
  input wire logic i_slow,
  output pcd_pkg::pcd_insn_t o_insn
);
  pcd_pkg::pcd_insn_t q[$];
  initial o_insn = '0;
  // One word a cycle, gaps when slow; idle bus shows junk, not the last word
  always @(posedge i_clk) begin
    if (q.size() != 0 && !(i_slow && $urandom_range(1) == 0)) o_insn <= q.pop_front();
    else o_insn <= {1'b0, ~o_insn[9:0]};
  end
endmodule

// *** test/pcd_prefix_code_decoder_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module pcd_prefix_code_decoder_tb_top;
  logic clk = 0, rst = 1, irq = 0, slow = 0, e;
  logic pready, pslverr, take, ssel, ms, pv, pc, ph, ev, ec, et, con, hd;
  logic [7:0] pbank = 8'h00;
  logic [31:0] r, prdata, bk;
  logic [4:0] bp;
  int bad_count = 0, samples_checked = 0, pb, i, j;
  pcd_pkg::pcd_apb_req_t apb = '0;
  pcd_pkg::pcd_insn_t ins, x;
  pcd_pkg::pcd_exec_t ex, ee;
  pcd_pkg::pcd_cls_t c, k;
  pcd_pkg::pcd_space_t stk;
  pcd_prefix_code_decoder dut (.i_clk(clk), .i_rst(rst), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_insn(ins), .i_program_bank(pbank), .i_irq_req(irq), .o_exec(ex), .o_irq_take(take),
    .o_stack_select(ssel));
  pcd_prog_mem mem (.i_clk(clk), .i_slow(slow), .o_insn(ins));
  initial forever #10 clk = ~clk;
  // Requester holds its line until accepted
  always @(posedge clk) irq <= rst ? 1'b0 : take ? 1'b0 : irq | ($urandom_range(5) == 0);
  // Reference model: check last edge's result, then step on this edge's inputs
  always @(posedge clk) begin
    if (rst) begin
      {pv, pc, ph, ev, ec, et, hd} = 7'h00;
      pb = 1; // Bank choice field idles at the data bank
      bp = 5'h00;
      bk = 32'h0;
      ms = 1'b1;
    end else begin
      `CHK(take, et)
      `CHK(ssel, ms)
      if (ev) `CHK(ex.valid, ee.valid)
      if (ec) `CHK(ex.cls, ee.cls)
      if (ec) `CHK(ex.regbank_en, ee.regbank_en)
      if (ec) `CHK(ex.space, ee.space)
      if (ec) `CHK(ex.bank, ee.bank)
      if (ec) `CHK(ex.flag_en, ee.flag_en)
      if (ec && ee.regbank_en) `CHK(ex.regbank_base, ee.regbank_base)
      c = ins.cls;
      stk = ms ? pcd_pkg::SPC_SYSTEM_STACK : pcd_pkg::SPC_USER_STACK;
      con = ins.valid && !(c >= pcd_pkg::CLS_PFX_PROGRAM || c inside {pcd_pkg::CLS_CCR_LOGIC,
        pcd_pkg::CLS_POP_PS, pcd_pkg::CLS_MOV_ILM});
      ee = '0;
      ee.valid = ins.valid;
      ee.cls = c;
      ee.regbank_en = ins.regbank;
      ee.space = ins.dflt_space;
      if (con && !ins.resume && pv && c inside {pcd_pkg::CLS_PLAIN, pcd_pkg::CLS_SWI, pcd_pkg::CLS_CTX_JUMP})
        ee.space = pb < 3 ? pcd_pkg::pcd_space_t'(pb) : stk;
      if (c inside {pcd_pkg::CLS_STACK_WORD, pcd_pkg::CLS_POP_PS}) ee.space = stk;
      if (c == pcd_pkg::CLS_IO) ee.space = pcd_pkg::SPC_IO;
      if (c == pcd_pkg::CLS_INTERRUPT_RETURN) ee.space = pcd_pkg::SPC_SYSTEM_STACK;
      ee.bank = ee.space == pcd_pkg::SPC_PROGRAM ? pbank : ee.space == pcd_pkg::SPC_IO ? 8'h00 :
        bk[8 * (ee.space - 1) +: 8];
      ee.flag_en = ins.flag_write && !(ph && con && !ins.resume && !(c inside {pcd_pkg::CLS_SWI,
        pcd_pkg::CLS_INTERRUPT_RETURN, pcd_pkg::CLS_CTX_JUMP}));
      ee.regbank_base = pc && con && !ins.resume ? 16'h0180 : 16'h0180 + {7'h00, bp, 4'h0};
      ev = c < pcd_pkg::CLS_PFX_PROGRAM || !ins.valid;
      ec = ins.valid && ev;
      et = con && irq;
      if (ins.valid && !con && irq) hd = 1'b1;
      else if (et || !irq) hd = 1'b0;
      if (con) {pv, pc, ph} = 3'h0;
      if (ins.valid && c >= pcd_pkg::CLS_PFX_PROGRAM) begin
        pv |= c <= pcd_pkg::CLS_PFX_STACK;
        if (c <= pcd_pkg::CLS_PFX_STACK) pb = c - pcd_pkg::CLS_PFX_PROGRAM;
        pc |= c == pcd_pkg::CLS_PFX_COMMON;
        ph |= c == pcd_pkg::CLS_PFX_FLAG_HOLD;
      end
      if (apb.psel && apb.penable && apb.pwrite && apb.paddr == pcd_pkg::PCD_CTRL_OFS) begin
        bp = apb.pwdata[4:0];
        ms = apb.pwdata[8];
      end
      if (apb.psel && apb.penable && apb.pwrite && apb.paddr == pcd_pkg::PCD_BANK_OFS) bk = apb.pwdata;
      if (et) ms = 1'b1;
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) apb <= '{1'b1, 1'b0, w, a, d, 4'hf};
    @(posedge clk) apb.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] xd, input logic xe);
    xfer(1'b0, a, 32'h0);
    `CHK(r, xd)
    `CHK(e, xe)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h6aaa));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(pcd_pkg::PCD_CTRL_OFS, 32'h100, 1'b0);
    rd(pcd_pkg::PCD_BANK_OFS, 32'h0, 1'b0);
    xfer(1'b1, 12'h00c, 32'hffffffff);
    rd(12'h00c, 32'h0, 1'b1);
    $display("reset test done");
    // Random batches: new banks, pointer and stack select, then a burst of instructions
    for (i = 0; i < 100; i++) begin
      xfer(1'b1, pcd_pkg::PCD_CTRL_OFS, $urandom);
      xfer(1'b1, pcd_pkg::PCD_BANK_OFS, $urandom);
      pbank <= 8'($urandom);
      slow <= 1'($urandom);
      for (j = 0; j < 30; j++) begin
        k = pcd_pkg::pcd_cls_t'($urandom_range(15));
        x = '{1'b1, k, pcd_pkg::pcd_space_t'($urandom_range(5)), 1'($urandom), 1'($urandom),
          k == pcd_pkg::CLS_STRING && $urandom_range(3) == 0};
        mem.q.push_back(x);
      end
      while (mem.q.size() != 0) @(posedge clk);
      repeat (3) @(posedge clk);
      rd(pcd_pkg::PCD_CTRL_OFS, {23'h0, ms, 3'h0, bp}, 1'b0);
      rd(pcd_pkg::PCD_BANK_OFS, bk, 1'b0);
      rd(pcd_pkg::PCD_STAT_OFS, {26'h0, hd, ph, pc, 2'(pb), pv}, 1'b0);
    end
    $display("stream test done");
    wrap_up();
  end
endmodule
